// >>> design/mcs_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef MCS_REGS_VH
`define MCS_REGS_VH
`define MCS_DEV_SETTINGS_ADDR   8'h00
`define MCS_CONV_SETTINGS_ADDR  8'h01
`define MCS_DEV_SETTINGS_RST    16'h0000
`define MCS_CONV_SETTINGS_RST   16'hfb68
`define MCS_DEV_WRITE_MASK      16'h3fd0
`define MCS_RESET_BIT           15
`define MCS_DELAY_MSB           13
`define MCS_DELAY_LSB           6
`define MCS_RANGE_BIT           4
`define MCS_MODE_MSB            15
`define MCS_MODE_LSB            12
`define MCS_BUS_CT_MSB          11
`define MCS_BUS_CT_LSB          9
`define MCS_SHUNT_CT_MSB        8
`define MCS_SHUNT_CT_LSB        6
`define MCS_TEMP_CT_MSB         5
`define MCS_TEMP_CT_LSB         3
`define MCS_AVG_MSB             2
`define MCS_AVG_LSB             0
`define MCS_CLK_MHZ             100
`define MCS_DELAY_STEP_MS       2
`define MCS_DELAY_STEP_CYC      (`MCS_DELAY_STEP_MS * 1000 * `MCS_CLK_MHZ)
`define MCS_US_CYC(us)          ((us) * `MCS_CLK_MHZ)
`endif

// >>> design/mcs_timer.v
// Cycle countdown timer used for delays and conversion durations
`timescale 1ns/1ps
module mcs_timer #(
  parameter W = 32
) (
  // Clock and reset
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         soft_rst,
  // Control
  input  wire         load,
  input  wire [W-1:0] count,
  // Status
  output reg          done
);
  reg [W-1:0] remain;
  reg         busy;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      remain <= {W{1'b0}};
      busy   <= 1'b0;
      done   <= 1'b0;
    end else if (soft_rst) begin
      remain <= {W{1'b0}};
      busy   <= 1'b0;
      done   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (load) begin
        remain <= count;
        busy   <= 1'b1;
      end else if (busy) begin
        if (remain <= {{(W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          remain <= remain - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // mcs_timer

// >>> design/mcs_core.v
// Conversion setup registers and channel sequencer of the power monitor
//
// What this block does
// - Writing one to bit 15 of device settings resets all registers to defaults and it reads 0.
// - The start delay field delays the first conversion by its value times 2 ms.
// - The range select bit picks the wide range at 0 and the narrow range at 1.
// - Reserved bits 14, 5 and 3..0 of device settings always read zero.
// - Mode codes 0 and 8 are shutdown and the mode field resets to continuous all channels, which a soft reset starts and sys_rst leaves idle.
// - Modes 1..7 run one triggered pass over bus (bit0), shunt (bit1), temperature (bit2).
// - Modes 9..15 repeat conversions forever over the channels in the low three bits.
// - Bus time codes 0..7 give 50..4120 us, default code 5.
// - Shunt time uses the same table, default code 5.
// - Temperature time uses the same table, default code 5.
// - Averaging codes 0..7 give 1,4,16,64,128,256,512,1024 samples, default 1.
// - Result registers update only after the whole averaging count completes.
`timescale 1ns/1ps
`include "mcs_regs.vh"
module mcs_core #(
  parameter DELAY_STEP_CYC = `MCS_DELAY_STEP_CYC,
  parameter TW             = 32
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Register access from the serial front end
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  // Converter control
  output reg         range_narrow,
  output reg         conv_active,
  output reg  [1:0]  conv_channel,
  output reg         sample_strobe,
  output reg         result_update,
  output reg         seq_busy
);
  localparam S_IDLE  = 3'd0;
  localparam S_DELAY = 3'd1;
  localparam S_PICK  = 3'd2;
  localparam S_CONV  = 3'd3;
  localparam S_WAIT  = 3'd4;
  localparam S_DONE  = 3'd5;

  localparam CH_BUS   = 2'd0;
  localparam CH_SHUNT = 2'd1;
  localparam CH_TEMP  = 2'd2;

  // ----------------------------------------------------------------
  // Lookup functions
  // ----------------------------------------------------------------
  function [TW-1:0] ct_cycles;
    input [2:0] code;
    begin
      case (code)
        3'd0:    ct_cycles = `MCS_US_CYC(50);
        3'd1:    ct_cycles = `MCS_US_CYC(84);
        3'd2:    ct_cycles = `MCS_US_CYC(150);
        3'd3:    ct_cycles = `MCS_US_CYC(280);
        3'd4:    ct_cycles = `MCS_US_CYC(540);
        3'd5:    ct_cycles = `MCS_US_CYC(1052);
        3'd6:    ct_cycles = `MCS_US_CYC(2074);
        default: ct_cycles = `MCS_US_CYC(4120);
      endcase
    end
  endfunction

  function [10:0] avg_samples;
    input [2:0] code;
    begin
      case (code)
        3'd0:    avg_samples = 11'h001;
        3'd1:    avg_samples = 11'h004;
        3'd2:    avg_samples = 11'h010;
        3'd3:    avg_samples = 11'h040;
        3'd4:    avg_samples = 11'h080;
        3'd5:    avg_samples = 11'h100;
        3'd6:    avg_samples = 11'h200;
        default: avg_samples = 11'h400;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [15:0] dev_settings;
  reg  [15:0] conv_settings;
  reg         soft_rst;
  reg         mode_written;

  wire wr_dev  = reg_wr && (reg_addr == `MCS_DEV_SETTINGS_ADDR);
  wire wr_conv = reg_wr && (reg_addr == `MCS_CONV_SETTINGS_ADDR);

  wire [7:0] start_delay_field   = dev_settings[`MCS_DELAY_MSB:`MCS_DELAY_LSB];
  wire [3:0] mode                = conv_settings[`MCS_MODE_MSB:`MCS_MODE_LSB];
  wire [2:0] bus_volt_time_sel   = conv_settings[`MCS_BUS_CT_MSB:`MCS_BUS_CT_LSB];
  wire [2:0] shunt_volt_time_sel = conv_settings[`MCS_SHUNT_CT_MSB:`MCS_SHUNT_CT_LSB];
  wire [2:0] temp_time_sel       = conv_settings[`MCS_TEMP_CT_MSB:`MCS_TEMP_CT_LSB];
  wire [2:0] averaging_count_sel = conv_settings[`MCS_AVG_MSB:`MCS_AVG_LSB];

  // Soft reset is a one-cycle pulse, so the reset bit never holds
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dev_settings  <= `MCS_DEV_SETTINGS_RST;
      conv_settings <= `MCS_CONV_SETTINGS_RST;
      soft_rst      <= 1'b0;
      mode_written  <= 1'b0;
      range_narrow  <= 1'b0;
    end else if (soft_rst) begin
      dev_settings  <= `MCS_DEV_SETTINGS_RST;
      conv_settings <= `MCS_CONV_SETTINGS_RST;
      soft_rst      <= 1'b0;
      mode_written  <= 1'b1;
      range_narrow  <= 1'b0;
    end else begin
      soft_rst     <= wr_dev && reg_wdata[`MCS_RESET_BIT];
      mode_written <= wr_conv;
      if (wr_dev) begin
        dev_settings <= reg_wdata & `MCS_DEV_WRITE_MASK;
        range_narrow <= reg_wdata[`MCS_RANGE_BIT];
      end
      if (wr_conv)
        conv_settings <= reg_wdata;
    end
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd) begin
      case (reg_addr)
        `MCS_DEV_SETTINGS_ADDR:  reg_rdata <= dev_settings;
        `MCS_CONV_SETTINGS_ADDR: reg_rdata <= conv_settings;
        default:                 reg_rdata <= 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  reg  [2:0]    state;
  reg  [2:0]    pending;
  reg  [10:0]   samples_left;
  reg  [7:0]    delay_left;
  reg           first_pass;
  reg           tmr_load;
  reg  [TW-1:0] tmr_count;
  wire          tmr_done;
  // Abandon a running count on restart, else a stale done fakes a sample
  wire          tmr_clear = soft_rst || mode_written;

  mcs_timer #(.W(TW)) u_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .soft_rst (tmr_clear),
    .load     (tmr_load),
    .count    (tmr_count),
    .done     (tmr_done)
  );

  wire       mode_off = (mode[2:0] == 3'b000);
  wire       mode_cont = mode[3];
  wire [1:0] next_ch = pending[0] ? CH_BUS : (pending[1] ? CH_SHUNT : CH_TEMP);
  wire [2:0] ch_time = (next_ch == CH_BUS) ? bus_volt_time_sel :
                       (next_ch == CH_SHUNT) ? shunt_volt_time_sel : temp_time_sel;

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state         <= S_IDLE;
      pending       <= 3'b000;
      samples_left  <= 11'h000;
      delay_left    <= 8'h00;
      first_pass    <= 1'b0;
      tmr_load      <= 1'b0;
      tmr_count     <= {TW{1'b0}};
      conv_active   <= 1'b0;
      conv_channel  <= CH_BUS;
      sample_strobe <= 1'b0;
      result_update <= 1'b0;
      seq_busy      <= 1'b0;
    end else if (soft_rst || mode_written) begin
      // A new mode restarts the sequence, including the start delay
      state         <= S_IDLE;
      first_pass    <= 1'b1;
      tmr_load      <= 1'b0;
      conv_active   <= 1'b0;
      sample_strobe <= 1'b0;
      result_update <= 1'b0;
      seq_busy      <= 1'b0;
    end else begin
      tmr_load      <= 1'b0;
      sample_strobe <= 1'b0;
      result_update <= 1'b0;
      case (state)
        S_IDLE: begin
          if (!mode_off && first_pass) begin
            seq_busy   <= 1'b1;
            first_pass <= 1'b0;
            delay_left <= start_delay_field;
            state      <= S_DELAY;
          end
        end
        S_DELAY: begin
          if (delay_left == 8'h00) begin
            pending <= mode[2:0];
            state   <= S_PICK;
          end else begin
            tmr_load   <= 1'b1;
            tmr_count  <= DELAY_STEP_CYC;
            delay_left <= delay_left - 8'h01;
            state      <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (tmr_done)
            state <= S_DELAY;
        end
        S_PICK: begin
          if (pending == 3'b000) begin
            if (mode_cont) begin
              pending <= mode[2:0];
            end else begin
              seq_busy <= 1'b0;
              state    <= S_DONE;
            end
          end else begin
            conv_channel <= next_ch;
            conv_active  <= 1'b1;
            samples_left <= avg_samples(averaging_count_sel);
            tmr_load     <= 1'b1;
            tmr_count    <= ct_cycles(ch_time);
            state        <= S_CONV;
          end
        end
        S_CONV: begin
          if (tmr_done) begin
            sample_strobe <= 1'b1;
            if (samples_left == 11'h001) begin
              result_update <= 1'b1;
              conv_active   <= 1'b0;
              pending       <= pending & ~(3'b001 << conv_channel);
              state         <= S_PICK;
            end else begin
              samples_left <= samples_left - 11'h001;
              tmr_load     <= 1'b1;
              tmr_count    <= ct_cycles(ch_time);
            end
          end
        end
        S_DONE: begin
          state <= S_DONE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // mcs_core

// >>> tb/mcs_props.sv
// Port-level checks of the conversion setup block
`timescale 1ns/1ps
module mcs_props (
  // Clock and reset
  input wire        clk,
  input wire        sys_rst,
  // Register access
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [7:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire [15:0] reg_rdata,
  // Converter control
  input wire        range_narrow,
  input wire        conv_active,
  input wire [1:0]  conv_channel,
  input wire        sample_strobe,
  input wire        result_update,
  input wire        seq_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_stop;
    reg_wr && reg_addr == 8'h01 && reg_wdata[14:12] == 3'h0;
  endsequence
  sequence s_soft;
    reg_wr && reg_addr == 8'h00 && reg_wdata[15];
  endsequence
  property p_unmapped; reg_rd && reg_addr > 8'h01 |=> reg_rdata == 16'h0000; endproperty
  property p_rsvd; reg_rd && reg_addr == 8'h00 |=> (reg_rdata & 16'hc02f) == 16'h0000; endproperty
  property p_range;
    reg_wr && reg_addr == 8'h00 && !reg_wdata[15] |=> range_narrow == $past(reg_wdata[4]);
  endproperty
  property p_soft; s_soft |-> ##[1:3] !range_narrow; endproperty
  property p_strobe; sample_strobe |=> !sample_strobe; endproperty
  property p_upd; result_update |=> !result_update; endproperty
  property p_upd_busy; result_update |-> seq_busy; endproperty
  property p_conv_busy; conv_active |-> seq_busy && conv_channel != 2'b11; endproperty
  property p_stop; s_stop |-> ##[1:4] (!conv_active && !seq_busy); endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  a_range: assert property (p_range) else $error("range select not applied");
  a_soft: assert property (p_soft) else $error("soft reset kept range");
  a_strobe: assert property (p_strobe) else $error("sample strobe too long");
  a_upd: assert property (p_upd) else $error("update pulse too long");
  a_upd_busy: assert property (p_upd_busy) else $error("update outside sequence");
  a_conv_busy: assert property (p_conv_busy) else $error("bad conversion state");
  a_stop: assert property (p_stop) else $error("shutdown not reached");
endmodule // mcs_props

bind mcs_core mcs_props u_props (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .range_narrow(range_narrow), .conv_active(conv_active), .conv_channel(conv_channel),
  .sample_strobe(sample_strobe), .result_update(result_update), .seq_busy(seq_busy));

// >>> tb/mcs_host.sv
// Serial front end model issuing one-cycle register strobes
`timescale 1ns/1ps
module mcs_host (
  // Clock
  input  wire        clk,
  // Register access
  output reg         reg_wr,
  output reg         reg_rd,
  output reg  [7:0]  reg_addr,
  output reg  [15:0] reg_wdata,
  input  wire [15:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge clk); #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk); #1;
      reg_wr = 1'b0;
      // Released data is not left looking valid
      reg_wdata = ~d;
    end
  endtask
  task rd(input [7:0] a, output [15:0] d);
    begin
      @(posedge clk); #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge clk); #1;
      reg_rd = 1'b0;
      d = reg_rdata;
    end
  endtask
endmodule // mcs_host

// >>> tb/tb.sv
// Self-checking bench of the conversion setup block
`timescale 1ns/1ps
module tb;
  reg clk;
  reg sys_rst;
  wire reg_wr, reg_rd, range_narrow, conv_active, sample_strobe, result_update, seq_busy;
  wire [7:0] reg_addr;
  wire [15:0] reg_wdata, reg_rdata;
  wire [1:0] conv_channel;
  integer fail_count = 0, samples_checked = 0, cyc = 0, ns, nu, first;
  reg [2:0] seen;
  reg [15:0] rv;
  // Short delay step keeps the start delay at 20 cycles per 2 codes
  mcs_core #(.DELAY_STEP_CYC(10)) u_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .range_narrow(range_narrow), .conv_active(conv_active), .conv_channel(conv_channel),
    .sample_strobe(sample_strobe), .result_update(result_update), .seq_busy(seq_busy));
  mcs_host u_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input [95:0] nm, input [15:0] e, input [15:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rchk(input [7:0] a, input [15:0] e);
    begin
      u_host.rd(a, rv);
      chk("rdata", e, rv);
    end
  endtask
  // Code 0 times give 5000 cycles a sample
  task run(input [15:0] cfg, input integer lim);
    integer i;
    begin
      ns = 0;
      nu = 0;
      first = -1;
      seen = 3'b000;
      u_host.wr(8'h01, cfg);
      repeat (3) @(posedge clk);
      for (i = 0; i < lim; i = i + 1) begin
        @(posedge clk); #1;
        if (sample_strobe === 1'b1) ns = ns + 1;
        if (result_update === 1'b1) nu = nu + 1;
        if (conv_active === 1'b1) seen[conv_channel] = 1'b1;
        if (conv_active === 1'b1 && first < 0) first = i;
      end
    end
  endtask
  task t_reset;
    begin
      rchk(8'h00, 16'h0000);
      rchk(8'h01, 16'hfb68);
      rchk(8'h05, 16'h0000);
      $display("reset test done");
    end
  endtask
  task t_rsvd;
    begin
      u_host.wr(8'h00, 16'h7fff);
      rchk(8'h00, 16'h3fd0);
      chk("narrow", 16'h0001, {15'h0000, range_narrow});
      u_host.wr(8'h00, 16'h0000);
      chk("wide", 16'h0000, {15'h0000, range_narrow});
      $display("reserved test done");
    end
  endtask
  task t_single;
    begin
      u_host.wr(8'h00, 16'h0080);
      run(16'h3000, 10060);
      // 20 delay cycles from the write plus a few cycles of sequencer overhead
      chk("delay", 16'h0001, {15'h0000, first >= 16 && first <= 28});
      chk("samples", 16'h0002, ns[15:0]);
      chk("updates", 16'h0002, nu[15:0]);
      chk("channels", 16'h0003, {13'h0000, seen});
      chk("stopped", 16'h0000, {15'h0000, seq_busy});
      $display("single test done");
    end
  endtask
  task t_avg;
    begin
      u_host.wr(8'h00, 16'h0000);
      run(16'h4001, 20080);
      chk("samples", 16'h0004, ns[15:0]);
      chk("updates", 16'h0001, nu[15:0]);
      chk("channels", 16'h0004, {13'h0000, seen});
      $display("average test done");
    end
  endtask
  task t_cont;
    begin
      run(16'h9000, 12000);
      chk("samples", 16'h0002, ns[15:0]);
      chk("running", 16'h0001, {15'h0000, seq_busy});
      u_host.wr(8'h01, 16'h8000);
      repeat (5) @(posedge clk);
      #1;
      chk("shutdown", 16'h0000, {15'h0000, seq_busy});
      $display("continuous test done");
    end
  endtask
  task t_soft;
    begin
      u_host.wr(8'h00, 16'h0010);
      u_host.wr(8'h00, 16'h8000);
      repeat (3) @(posedge clk);
      #1;
      chk("range", 16'h0000, {15'h0000, range_narrow});
      chk("restart", 16'h0001, {15'h0000, seq_busy});
      rchk(8'h00, 16'h0000);
      rchk(8'h01, 16'hfb68);
      u_host.wr(8'h01, 16'h0000);
      $display("soft reset test done");
    end
  endtask
  task final_report;
    begin
      $display("checked %0d failed %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // Ceiling well above the 42k cycles the tests need
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fail_count = fail_count + 1;
      final_report;
    end
  end
  initial begin
    sys_rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_reset;
    t_rsvd;
    t_single;
    t_avg;
    t_cont;
    t_soft;
    final_report;
  end
endmodule // tb
